// ---- core/csr_top.sv ----
// Charger setpoint register bank: three word registers, range checks,
// charge permit, battery-voltage foldback and input power sharing.
// Assumes a word-level serial engine in front and comparator pins from the analog side.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Voltage bits 11-14 weigh 2048..16384 mV, bit15 ignored
// - Current bits 7-12 form 128..4096 mA code
// - Charge current written by command 0x14
// - Accept charge current 128 mA to 8064 mA
// - Charge current zero terminates charging
// - Out-of-range current clears register, stops charging
// - Between 2.5 and 3.6 V clamp at 3 A
// - Below 2.5 V force 220 mA until 2.7 V
// - Foldback keeps stored current, restores it afterwards
// - Reset clears current and voltage setpoints; charger off until both written
// - Switch drives off in reset and until start
// - Input over limit lowers charge current
// - Input limit written by command 0x3f
// - Accept input limit above 256 mA up to 11008 mA
// - Input write 1..256 mA clears, stops charging
// - Input limit resets to 256 mA
// - Input bits 7-11 weigh 256..4096 mA
// - Input bit 12 weighs 8192 mA, max 11008
// - Charge voltage written by command 0x15
// - Voltage outside 1024..19200 mV clears, stops charging
// - Voltage bits 4-10 weigh 16..1024 mV
module csr_top
    import csr_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic wr_en,
    input wire csr_wr_t wr_req,
    input wire logic rd_en,
    input wire logic [7:0] rd_cmd,
    input wire logic [CSR_CMP_W-1:0] cmp_pins,
    output logic [15:0] rd_data,
    output logic rd_valid,
    output csr_apply_t applied,
    output logic charge_enable,
    output logic hs_drive_on,
    output logic ls_drive_on
);

    // Range check of a charge-current word
    function automatic logic cur_ok(input logic [15:0] raw);
        cur_ok = (raw >= CSR_CUR_MIN) && (raw <= CSR_CUR_MAX);
    endfunction

    // Range check of a charge-voltage word, top bit ignored
    function automatic logic volt_ok(input logic [15:0] raw);
        logic [15:0] v;
        v = raw;
        v[CSR_VOLT_TOP_BIT] = 1'b0;
        volt_ok = (v >= CSR_VOLT_MIN) && (v <= CSR_VOLT_MAX);
    endfunction

    // Range check of an input-limit word; zero up to the 256 mA step is refused
    function automatic logic in_ok(input logic [15:0] raw);
        in_ok = (raw > CSR_IN_BAD_MAX) && (raw <= CSR_IN_MAX);
    endfunction

    logic [15:0] charge_current_setpoint; // Stored current word
    logic [15:0] charge_voltage_setpoint; // Stored voltage word
    logic [15:0] input_current_limit; // Stored input limit word
    logic [CSR_CMP_W-1:0] cmp_sync; // Filtered comparator levels
    logic fold_deep; // Deep foldback latch
    logic [15:0] share_cut; // Current taken away for system load
    logic [15:0] target_ma; // Current after foldback
    logic [15:0] next_cut; // Next power-sharing cut
    logic permit; // All setpoints nonzero

    // Comparator pins cross into the clock domain here
    csr_sync #(
        .WIDTH(CSR_CMP_W)
    ) u_sync (
        .clk(clk),
        .resetn(resetn),
        .pin_in(cmp_pins),
        .sync_out(cmp_sync)
    );

    // Charge-current register; invalid words clear it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            charge_current_setpoint <= CSR_RST_CURRENT;
        end else if (wr_en && wr_req.cmd == CSR_CMD_CHARGE_CURRENT) begin
            if (cur_ok(wr_req.data)) begin
                // Only the six code bits are kept
                charge_current_setpoint <= wr_req.data & CSR_MASK_CURRENT;
            end else begin
                // Zero and out-of-range both leave the register empty
                charge_current_setpoint <= CSR_RST_CURRENT;
            end
        end
    end

    // Charge-voltage register; invalid words clear it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            charge_voltage_setpoint <= CSR_RST_VOLTAGE;
        end else if (wr_en && wr_req.cmd == CSR_CMD_CHARGE_VOLTAGE) begin
            if (volt_ok(wr_req.data)) begin
                // Bits 4 to 14 carry 16 mV up to 16384 mV
                charge_voltage_setpoint <= wr_req.data & CSR_MASK_VOLTAGE;
            end else begin
                charge_voltage_setpoint <= CSR_RST_VOLTAGE;
            end
        end
    end

    // Input-limit register; resets to the lowest step, not to zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            input_current_limit <= CSR_RST_INPUT;
        end else if (wr_en && wr_req.cmd == CSR_CMD_INPUT_LIMIT) begin
            if (in_ok(wr_req.data)) begin
                // Bits 7 to 12 carry 256 mA up to 8192 mA
                input_current_limit <= wr_req.data & CSR_MASK_INPUT;
            end else begin
                input_current_limit <= 16'h0000;
            end
        end
    end

    // Read answer one cycle after the request; unknown commands read zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_data <= 16'h0000;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_en;
            if (rd_en) begin
                unique case (rd_cmd)
                    CSR_CMD_CHARGE_CURRENT: rd_data <= charge_current_setpoint;
                    CSR_CMD_CHARGE_VOLTAGE: rd_data <= charge_voltage_setpoint;
                    CSR_CMD_INPUT_LIMIT: rd_data <= input_current_limit;
                    default: rd_data <= 16'h0000;
                endcase
            end
        end
    end

    // Charging allowed only with every setpoint nonzero after its checks.
    // Current and voltage registers start at zero, so this also waits for both writes after reset.
    assign permit = (charge_current_setpoint != 16'h0000)
        && (charge_voltage_setpoint != 16'h0000)
        && (input_current_limit != 16'h0000);

    // Deep foldback latch with hysteresis between 2.5 V and 2.7 V
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fold_deep <= 1'b0;
        end else if (cmp_sync[CSR_CMP_BELOW_2V5]) begin
            fold_deep <= 1'b1;
        end else if (cmp_sync[CSR_CMP_ABOVE_2V7]) begin
            fold_deep <= 1'b0;
        end
    end

    // Foldback acts on the applied value only; the register is untouched
    always_comb begin
        target_ma = charge_current_setpoint;
        if (fold_deep) begin
            target_ma = CSR_FOLD_DEEP_MA;
        end else if (cmp_sync[CSR_CMP_BELOW_3V6] && charge_current_setpoint > CSR_FOLD_MID_MA) begin
            target_ma = CSR_FOLD_MID_MA;
        end
    end

    // Power sharing: ramp the cut one step per cycle, a crude digital loop
    // that trades smoothness for a fixed, small amount of logic.
    always_comb begin
        next_cut = share_cut;
        if (cmp_sync[CSR_CMP_INPUT_OVER]) begin
            if (share_cut < target_ma) begin
                next_cut = share_cut + CSR_SHARE_STEP_MA;
            end
        end else if (share_cut >= CSR_SHARE_STEP_MA) begin
            next_cut = share_cut - CSR_SHARE_STEP_MA;
        end else begin
            next_cut = 16'h0000;
        end
    end

    // Power-sharing cut register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            share_cut <= 16'h0000;
        end else begin
            share_cut <= next_cut;
        end
    end

    // Applied setpoints and permit, all registered
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            applied <= '0;
            charge_enable <= 1'b0;
        end else begin
            charge_enable <= permit;
            applied.voltage_mv <= charge_voltage_setpoint;
            applied.input_ma <= input_current_limit;
            if (!permit) begin
                applied.current_ma <= 16'h0000;
            end else if (share_cut >= target_ma) begin
                applied.current_ma <= 16'h0000;
            end else begin
                applied.current_ma <= target_ma - share_cut;
            end
        end
    end

    // Both switch drives stay off until the charger is permitted
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hs_drive_on <= 1'b0;
            ls_drive_on <= 1'b0;
        end else begin
            hs_drive_on <= permit;
            ls_drive_on <= permit;
        end
    end

    // Checks on the block's own registers and outputs
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_cur_bad_clear: assert property (wr_en && wr_req.cmd == CSR_CMD_CHARGE_CURRENT && !cur_ok(wr_req.data)
        |=> charge_current_setpoint == 16'h0000 ##1 !charge_enable)
        else $error("bad current word not cleared");
    a_cur_stored_masked: assert property (wr_en && wr_req.cmd == CSR_CMD_CHARGE_CURRENT && cur_ok(wr_req.data)
        |=> charge_current_setpoint == ($past(wr_req.data) & CSR_MASK_CURRENT))
        else $error("current word stored wrongly");
    a_volt_bad_clear: assert property (wr_en && wr_req.cmd == CSR_CMD_CHARGE_VOLTAGE && !volt_ok(wr_req.data)
        |=> charge_voltage_setpoint == 16'h0000 ##1 !charge_enable)
        else $error("bad voltage word not cleared");
    a_in_bad_clear: assert property (wr_en && wr_req.cmd == CSR_CMD_INPUT_LIMIT && !in_ok(wr_req.data)
        |=> input_current_limit == 16'h0000 ##1 !charge_enable)
        else $error("bad input word not cleared");
    a_enable_needs_all: assert property (charge_enable |-> $past(charge_current_setpoint) != 16'h0000
        && $past(charge_voltage_setpoint) != 16'h0000 && $past(input_current_limit) != 16'h0000)
        else $error("charging without valid setpoints");
    a_drive_follows_en: assert property (!charge_enable |-> !hs_drive_on && !ls_drive_on)
        else $error("switch drive on while disabled");
    a_deep_fold_cap: assert property (fold_deep |=> applied.current_ma <= CSR_FOLD_DEEP_MA)
        else $error("deep foldback current exceeded");
    a_mid_fold_cap: assert property (cmp_sync[CSR_CMP_BELOW_3V6] |=> applied.current_ma <= CSR_FOLD_MID_MA)
        else $error("mid foldback current exceeded");
    a_fold_keeps_reg: assert property (fold_deep && !(wr_en && wr_req.cmd == CSR_CMD_CHARGE_CURRENT)
        |=> $stable(charge_current_setpoint))
        else $error("foldback changed stored current");
    a_share_cut_grows: assert property (cmp_sync[CSR_CMP_INPUT_OVER] && share_cut < target_ma
        |=> share_cut == $past(share_cut) + CSR_SHARE_STEP_MA)
        else $error("power sharing did not reduce current");
    a_read_answer: assert property (rd_en |=> rd_valid)
        else $error("read not answered");

    c_charging: cover property (charge_enable ##1 applied.current_ma != 16'h0000);
    c_deep_fold: cover property (charge_enable && fold_deep);
    c_bad_write: cover property (wr_en && wr_req.cmd == CSR_CMD_CHARGE_VOLTAGE && !volt_ok(wr_req.data));
    c_sharing: cover property (charge_enable && share_cut != 16'h0000);

endmodule

`default_nettype wire

// ---- core/csr_pkg.sv ----
// Constants, codes and carrier types for the charger setpoint register bank.
// Assumes current and voltage words count one mA or mV per LSB; the input-limit
// word counts two mA per LSB, so its range figures are in word units.
package csr_pkg;

    // Write-Word and Read-Word command codes
    localparam logic [7:0] CSR_CMD_CHARGE_CURRENT = 8'h14;
    localparam logic [7:0] CSR_CMD_CHARGE_VOLTAGE = 8'h15;
    localparam logic [7:0] CSR_CMD_INPUT_LIMIT = 8'h3f;

    // Field masks of the used bit positions
    localparam logic [15:0] CSR_MASK_CURRENT = 16'h1f80;
    localparam logic [15:0] CSR_MASK_VOLTAGE = 16'h7ff0;
    localparam logic [15:0] CSR_MASK_INPUT = 16'h1f80;

    // Voltage field ignores its top bit
    localparam int CSR_VOLT_TOP_BIT = 15;

    // Reset values
    localparam logic [15:0] CSR_RST_CURRENT = 16'h0000;
    localparam logic [15:0] CSR_RST_VOLTAGE = 16'h0000;
    localparam logic [15:0] CSR_RST_INPUT = 16'h0080;

    // Valid ranges
    localparam logic [15:0] CSR_CUR_MIN = 16'h0080;
    localparam logic [15:0] CSR_CUR_MAX = 16'h1f80;
    localparam logic [15:0] CSR_VOLT_MIN = 16'h0400;
    localparam logic [15:0] CSR_VOLT_MAX = 16'h4b00;
    localparam logic [15:0] CSR_IN_BAD_MAX = 16'h0080; // 256 mA, highest refused word
    localparam logic [15:0] CSR_IN_MAX = 16'h1580; // 11008 mA at two mA per LSB

    // Foldback and power-sharing figures in mA
    localparam logic [15:0] CSR_FOLD_DEEP_MA = 16'h00dc;
    localparam logic [15:0] CSR_FOLD_MID_MA = 16'h0bb8;
    localparam logic [15:0] CSR_SHARE_STEP_MA = 16'h0080;

    // Comparator inputs and their synchroniser width
    localparam int CSR_CMP_W = 4;
    localparam int CSR_CMP_BELOW_3V6 = 0;
    localparam int CSR_CMP_BELOW_2V5 = 1;
    localparam int CSR_CMP_ABOVE_2V7 = 2;
    localparam int CSR_CMP_INPUT_OVER = 3;

    // One word write from the serial engine
    typedef struct packed {
        logic [7:0] cmd;
        logic [15:0] data;
    } csr_wr_t;

    // Applied setpoints towards the analog loops
    typedef struct packed {
        logic [15:0] current_ma;
        logic [15:0] voltage_mv;
        logic [15:0] input_ma;
    } csr_apply_t;

endpackage

// ---- core/csr_sync.sv ----
// Three-stage synchroniser with agreement filter for comparator pins.
// Assumes asynchronous inputs; output moves once stages two and three agree.
`timescale 1ns/10ps
`default_nettype none

module csr_sync
    import csr_pkg::*;
#(
    parameter int WIDTH = CSR_CMP_W
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] sync_out
);

    // Per-bit chain, kept separate so each bit filters on its own
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
            logic ff1; // Metastable stage, read by ff2 only
            logic ff2; // Settled stage
            logic ff3; // Agreement stage

            // Shift chain
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    ff1 <= 1'b0;
                    ff2 <= 1'b0;
                    ff3 <= 1'b0;
                end else begin
                    ff1 <= pin_in[gi];
                    ff2 <= ff1;
                    ff3 <= ff2;
                end
            end

            // Accept a change only when two settled stages agree
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    sync_out[gi] <= 1'b0;
                end else if (ff2 == ff3) begin
                    sync_out[gi] <= ff3;
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// ---- tb/csr_host_model.sv ----
// Host controller model: word-level Write-Word and Read-Word requests to the bank.
// Assumes requests are taken on the rising edge and a read answers one cycle later.
`timescale 1ns/10ps
`default_nettype none

module csr_host_model
    import csr_pkg::*;
(
    input wire logic clk,
    output logic wr_en,
    output csr_wr_t wr_req,
    output logic rd_en,
    output logic [7:0] rd_cmd,
    input wire logic [15:0] rd_data,
    input wire logic rd_valid
);
    // Idle request lines at time zero
    initial begin
        wr_en = 1'b0;
        wr_req = '0;
        rd_en = 1'b0;
        rd_cmd = 8'h00;
    end

    // Whole word with its command code in one strobe
    // Voltage words under 1024 mV are sent only when a caller wants a refusal
    task automatic write_word(input logic [7:0] cmd, input logic [15:0] data);
        @(posedge clk);
        wr_en <= 1'b1;
        wr_req <= {cmd, data};
        @(posedge clk);
        wr_en <= 1'b0;
        // Released lines change, so a stale word cannot pass for a request
        wr_req <= ~wr_req;
    endtask

    // Read with a bounded wait for the answer strobe
    task automatic read_word(input logic [7:0] cmd, output logic [15:0] data, output logic ok);
        ok = 1'b0;
        data = 16'h0000;
        @(posedge clk);
        rd_en <= 1'b1;
        rd_cmd <= cmd;
        @(posedge clk);
        rd_en <= 1'b0;
        rd_cmd <= ~cmd;
        for (int i = 0; i < 4 && !ok; i++) begin
            #1;
            if (rd_valid === 1'b1) begin
                data = rd_data;
                ok = 1'b1;
            end else begin
                @(posedge clk);
            end
        end
    endtask
endmodule

`default_nettype wire

// ---- tb/test_charger_setpoint_registers.sv ----
// Self-checking bench for the charger setpoint register bank.
// Assumes the host model drives the word bus and the bench drives comparator pins.
`timescale 1ns/10ps
`default_nettype none

module test_charger_setpoint_registers
    import csr_pkg::*;
;
    logic clk;
    logic resetn;
    logic [CSR_CMP_W-1:0] cmp_pins;
    logic wr_en;
    logic rd_en;
    csr_wr_t wr_req;
    logic [7:0] rd_cmd;
    logic [15:0] rd_data;
    logic rd_valid;
    csr_apply_t applied;
    logic charge_enable;
    logic hs_drive_on;
    logic ls_drive_on;
    int mismatches;
    int checks;
    // One range case: command, word written, word kept, permit after
    typedef struct packed {logic [7:0] cmd; logic [15:0] data; logic [15:0] kept; logic en;} csr_case_t;
    csr_case_t cases [16];

    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    csr_host_model i_host (.clk(clk), .wr_en(wr_en), .wr_req(wr_req), .rd_en(rd_en), .rd_cmd(rd_cmd),
        .rd_data(rd_data), .rd_valid(rd_valid));

    csr_top i_dut (.clk(clk), .resetn(resetn), .wr_en(wr_en), .wr_req(wr_req), .rd_en(rd_en),
        .rd_cmd(rd_cmd), .cmp_pins(cmp_pins), .rd_data(rd_data), .rd_valid(rd_valid), .applied(applied),
        .charge_enable(charge_enable), .hs_drive_on(hs_drive_on), .ls_drive_on(ls_drive_on));

    // Verdict and end of run
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Compare seen against expected
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Read and compare; a missing answer ends the run
    task automatic rd_chk(input logic [7:0] cmd, input logic [15:0] exp);
        logic [15:0] v;
        logic ok;
        i_host.read_word(cmd, v, ok);
        if (!ok) begin
            mismatches++;
            wrap_up();
        end else begin
            chk(v, exp);
        end
    endtask

    // Let n edges pass, then sample settled outputs
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    initial begin
        resetn = 1'b0;
        cmp_pins = '0;
        mismatches = 0;
        checks = 0;
        // Edge cases of each range, valid restore after each refusal
        cases = '{'{8'h14, 16'h0000, 16'h0000, 1'b0}, '{8'h14, 16'h0080, 16'h0080, 1'b1},
            '{8'h14, 16'h007f, 16'h0000, 1'b0}, '{8'h14, 16'h1f80, 16'h1f80, 1'b1},
            '{8'h14, 16'h1f81, 16'h0000, 1'b0}, '{8'h14, 16'h0c00, 16'h0c00, 1'b1},
            '{8'h15, 16'h03ff, 16'h0000, 1'b0}, '{8'h15, 16'h0400, 16'h0400, 1'b1},
            '{8'h15, 16'h4b01, 16'h0000, 1'b0}, '{8'h15, 16'h4b00, 16'h4b00, 1'b1},
            '{8'h3f, 16'h0080, 16'h0000, 1'b0}, '{8'h3f, 16'h0180, 16'h0180, 1'b1},
            '{8'h3f, 16'h0001, 16'h0000, 1'b0}, '{8'h3f, 16'h1580, 16'h1580, 1'b1},
            '{8'h3f, 16'h1581, 16'h0000, 1'b0}, '{8'h3f, 16'h0c00, 16'h0c00, 1'b1}};
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        cyc(1);
        chk({15'h0, charge_enable | hs_drive_on | ls_drive_on}, 16'h0000);
        chk(applied.input_ma, 16'h0080);
        rd_chk(CSR_CMD_CHARGE_CURRENT, 16'h0000);
        rd_chk(CSR_CMD_CHARGE_VOLTAGE, 16'h0000);
        rd_chk(CSR_CMD_INPUT_LIMIT, 16'h0080);
        // Voltage alone must not start the charger
        i_host.write_word(CSR_CMD_CHARGE_VOLTAGE, 16'hc1a5);
        cyc(3);
        chk({15'h0, charge_enable}, 16'h0000);
        rd_chk(CSR_CMD_CHARGE_VOLTAGE, 16'h41a0);
        i_host.write_word(CSR_CMD_CHARGE_CURRENT, 16'h0c7f);
        cyc(3);
        chk({15'h0, charge_enable & hs_drive_on & ls_drive_on}, 16'h0001);
        rd_chk(CSR_CMD_CHARGE_CURRENT, 16'h0c00);
        chk(applied.current_ma, 16'h0c00);
        chk(applied.voltage_mv, 16'h41a0);
        // Unknown codes are ignored and read as zero
        i_host.write_word(8'h20, 16'h1234);
        rd_chk(8'h20, 16'h0000);
        rd_chk(8'hfe, 16'h0000);
        // Foldback walk: mid clamp, deep, hysteresis, recovery
        cmp_pins <= 4'b0001;
        cyc(7);
        chk(applied.current_ma, 16'h0bb8);
        cmp_pins <= 4'b0011;
        cyc(7);
        chk(applied.current_ma, 16'h00dc);
        cmp_pins <= 4'b0001;
        cyc(7);
        chk(applied.current_ma, 16'h00dc);
        rd_chk(CSR_CMD_CHARGE_CURRENT, 16'h0c00);
        cmp_pins <= 4'b0100;
        cyc(7);
        chk(applied.current_ma, 16'h0c00);
        // Input over limit ramps charge current to nothing, then back
        cmp_pins <= 4'b1100;
        cyc(40);
        chk(applied.current_ma, 16'h0000);
        cmp_pins <= 4'b0100;
        cyc(40);
        chk(applied.current_ma, 16'h0c00);
        // Range table; refusals clear the register and drop the permit
        foreach (cases[k]) begin
            i_host.write_word(cases[k].cmd, cases[k].data);
            cyc(3);
            chk({15'h0, charge_enable}, {15'h0, cases[k].en});
            rd_chk(cases[k].cmd, cases[k].kept);
        end
        // Second reset in mid-charge
        @(posedge clk);
        resetn <= 1'b0;
        #1;
        chk({15'h0, charge_enable | hs_drive_on | ls_drive_on}, 16'h0000);
        cyc(3);
        resetn <= 1'b1;
        cyc(1);
        rd_chk(CSR_CMD_CHARGE_CURRENT, 16'h0000);
        rd_chk(CSR_CMD_INPUT_LIMIT, 16'h0080);
        wrap_up();
    end
endmodule

`default_nettype wire
